// ### icdu_osc_model.sv
// oscillator source model feeding the divider unit
// assumes a free running source; one period is one oscillator period
`timescale 1ns/1ps
module icdu_osc_model #(
    parameter real HALF_NS = 2.5
) (
    // oscillator output
    output logic osc_clk
);
    initial osc_clk = 1'b0;
    // free running, as a crystal never stops between uses
    always #(HALF_NS) osc_clk = ~osc_clk;
endmodule : icdu_osc_model

// ### icdu_phase_gen.sv
// low/high phase clock generator advancing on a tick
// assumes cfg may change at any time; it is sampled only at a low-phase start, or every cycle while bypass is high
`timescale 1ns/1ps
module icdu_phase_gen (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    // control
    input  wire logic                     adv,
    input  wire logic                     bypass,
    input  wire icdu_pkg::icdu_phase_type cfg,
    // generated clock
    output icdu_pkg::icdu_edge_type       clk_o,
    output logic [4:0]                    span
);
    import icdu_pkg::*;

    icdu_state_type state_ff;
    logic [3:0]     cnt_ff;
    icdu_phase_type cur_ff;
    logic           rise_ff;
    logic           fall_ff;
    logic [4:0]     span_ff;
    logic           done;

    assign done = adv && !bypass && (cnt_ff == ((state_ff == PH_LOW) ? cur_ff.low : cur_ff.high));

    ////////////////////////////////////////////////////////////////////////
    // new lengths only at the high-to-low boundary or while bypass is high, so no runt phase
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= PH_HIGH;
            cur_ff   <= '0;
        end else if (bypass) begin
            state_ff <= PH_HIGH;
            cur_ff   <= cfg;
        end else if (done) begin
            case (state_ff)
                PH_HIGH: begin
                    state_ff <= PH_LOW;
                    cur_ff   <= cfg;
                end
                PH_LOW: begin
                    state_ff <= PH_HIGH;
                end
                default: begin
                    state_ff <= PH_HIGH;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= 4'h0;
        end else if (bypass || done) begin
            cnt_ff <= 4'h0;
        end else if (adv) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // edge pulses and length of the phase just ended, in ticks
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
            span_ff <= 5'h00;
        end else begin
            rise_ff <= bypass ? adv : (done && state_ff == PH_LOW);
            fall_ff <= done && state_ff == PH_HIGH;
            if (done) begin
                span_ff <= {1'b0, cnt_ff} + 5'h01;
            end
        end
    end

    assign clk_o = '{lvl: (state_ff == PH_HIGH), rise: rise_ff, fall: fall_ff};
    assign span  = span_ff;

endmodule : icdu_phase_gen

// ### icdu_pkg.sv
// constants, types and helpers for the internal clock divider unit
// assumes one oscillator period equals one core_clk cycle
package icdu_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_MODE  = 8'h01;
    localparam logic [7:0] IDX_UART  = 8'h0F;
    localparam logic [7:0] IDX_TMR1  = 8'h12;
    localparam logic [7:0] IDX_TMR2  = 8'h13;
    localparam logic [7:0] IDX_STAT  = 8'h20;

    // field positions
    localparam int unsigned MODE_CPU_LSB = 0;
    localparam int unsigned MODE_BUS_LSB = 2;
    localparam int unsigned LOW_LSB      = 0;
    localparam int unsigned HIGH_LSB     = 4;

    // values after reset
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_UART = 8'h77;
    localparam logic [7:0] RST_TMR1 = 8'h77;
    localparam logic [7:0] RST_TMR2 = 8'h00;

    // divider codes
    localparam logic [1:0] CPU_DIV1    = 2'h0;
    localparam logic [1:0] CPU_DIV2    = 2'h1;
    localparam logic [1:0] CPU_DIV3    = 2'h2;
    localparam logic [1:0] CPU_DIV4    = 2'h3;
    localparam logic [1:0] BUS_DIV4    = 2'h0;
    localparam logic [1:0] BUS_DIV3    = 2'h1;
    localparam logic [1:0] BUS_DIV2    = 2'h2;
    localparam logic [1:0] BUS_ILLEGAL = 2'h3;

    // cycles without a register write before phase checks apply
    localparam logic [5:0] QUIET_CYCLES = 6'h28;

    ////////////////////////////////////////////////////////////////////////
    // phase lengths are stored as length minus one
    typedef struct packed {
        logic [3:0] high;
        logic [3:0] low;
    } icdu_phase_type;

    typedef struct packed {
        logic lvl;
        logic rise;
        logic fall;
    } icdu_edge_type;

    typedef enum logic {PH_LOW, PH_HIGH} icdu_state_type;

    function automatic logic [7:0] icdu_byte_addr(input logic [7:0] idx);
        return {idx[5:0], 2'h0};
    endfunction : icdu_byte_addr

    function automatic icdu_phase_type icdu_cpu_phase(input logic [1:0] sel);
        icdu_phase_type p;
        p = '0;
        case (sel)
            CPU_DIV3: p.low  = 4'h1;
            CPU_DIV4: p = '{high: 4'h1, low: 4'h1};
            default:  p = '0;
        endcase
        return p;
    endfunction : icdu_cpu_phase

    function automatic icdu_phase_type icdu_bus_phase(input logic [1:0] sel);
        icdu_phase_type p;
        p = '0;
        case (sel)
            BUS_DIV4: p = '{high: 4'h1, low: 4'h1};
            BUS_DIV3: p.low = 4'h1;
            default:  p = '0;
        endcase
        return p;
    endfunction : icdu_bus_phase

endpackage : icdu_pkg

// ### icdu_top.sv
// internal clock divider unit: processor, bus, uart and timer clocks
// assumes core_clk is the main oscillator input and an APB master
//
// Operation
// - The processor clock divides the oscillator by 1, 2, 3 or 4 for codes 00 to 11.
// - Processor phases are 1/1 for divide-by-2, 2 low 1 high for 3, and 2/2 for 4 oscillator periods.
// - The bus clock divides the processor clock by 4, 3 or 2 for codes 00 to 10; code 11 is illegal.
// - Bus phases are 2/2, 2 low 1 high and 1/1 processor periods for divide-by 4, 3 and 2.
// - Both divider fields live in the clock divider mode register at index 01.
// - The uart clock low phase lasts its low count plus one oscillator periods, set at index 0F.
// - The uart clock high phase lasts its high count plus one periods; the period is their sum.
// - The timer clock low phase normally lasts its low count plus one periods, set at index 12.
// - When the alternate trigger count is reached, that one low phase uses the alternate count plus one.
// - The timer clock high phase lasts its high count plus one periods, set at index 12.
`timescale 1ns/1ps
module icdu_top (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               resetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // generated clocks
    output icdu_pkg::icdu_edge_type processor_clock,
    output icdu_pkg::icdu_edge_type bus_clock,
    output icdu_pkg::icdu_edge_type uart_clock,
    output icdu_pkg::icdu_edge_type timer_clock
);
    import icdu_pkg::*;

    logic [7:0]     clock_divider_mode_ff;
    logic [7:0]     uart_clock_control_ff;
    logic [7:0]     timer_clock_control_one_ff;
    logic [7:0]     timer_clock_control_two_ff;
    logic [31:0]    prdata_ff;
    logic [3:0]     tcyc_ff;
    logic           alt_used_ff;
    logic [5:0]     quiet_ff;

    logic [1:0]     processor_divide_select;
    logic [1:0]     bus_divide_select;
    logic [3:0]     uart_low_count;
    logic [3:0]     uart_high_count;
    logic [3:0]     timer_low_count;
    logic [3:0]     timer_high_count;
    logic [3:0]     timer_alternate_trigger_count;
    logic [3:0]     timer_alternate_low_count;

    logic           hit_mode;
    logic           hit_uart;
    logic           hit_tmr1;
    logic           hit_tmr2;
    logic           hit_stat;
    logic           mapped;
    logic           bad_bus;
    logic           wr_en;
    logic [7:0]     rd_byte;
    logic           quiet;

    icdu_phase_type cpu_cfg;
    icdu_phase_type bus_cfg;
    icdu_phase_type uart_cfg;
    icdu_phase_type tmr_cfg;
    logic [4:0]     cpu_span;
    logic [4:0]     bus_span;
    logic [4:0]     uart_span;
    logic [4:0]     tmr_span;

    ////////////////////////////////////////////////////////////////////////
    // field extraction
    assign processor_divide_select       = clock_divider_mode_ff[MODE_CPU_LSB +: 2];
    assign bus_divide_select             = clock_divider_mode_ff[MODE_BUS_LSB +: 2];
    assign uart_low_count                = uart_clock_control_ff[LOW_LSB +: 4];
    assign uart_high_count               = uart_clock_control_ff[HIGH_LSB +: 4];
    assign timer_low_count               = timer_clock_control_one_ff[LOW_LSB +: 4];
    assign timer_high_count              = timer_clock_control_one_ff[HIGH_LSB +: 4];
    assign timer_alternate_trigger_count = timer_clock_control_two_ff[LOW_LSB +: 4];
    assign timer_alternate_low_count     = timer_clock_control_two_ff[HIGH_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, read data captured in the setup cycle
    assign hit_mode = (paddr == icdu_byte_addr(IDX_MODE));
    assign hit_uart = (paddr == icdu_byte_addr(IDX_UART));
    assign hit_tmr1 = (paddr == icdu_byte_addr(IDX_TMR1));
    assign hit_tmr2 = (paddr == icdu_byte_addr(IDX_TMR2));
    assign hit_stat = (paddr == icdu_byte_addr(IDX_STAT));
    assign mapped   = hit_mode || hit_uart || hit_tmr1 || hit_tmr2 || hit_stat;
    // illegal bus code is refused rather than stored
    assign bad_bus  = hit_mode && pwrite && pstrb[0] && (pwdata[MODE_BUS_LSB +: 2] == BUS_ILLEGAL);
    assign pready   = psel && penable;
    assign pslverr  = psel && penable && (!mapped || bad_bus);
    assign wr_en    = psel && penable && pwrite && pstrb[0] && !pslverr;
    assign prdata   = prdata_ff;

    always_comb begin
        rd_byte = 8'h00;
        if (hit_mode) begin
            rd_byte = clock_divider_mode_ff;
        end else if (hit_uart) begin
            rd_byte = uart_clock_control_ff;
        end else if (hit_tmr1) begin
            rd_byte = timer_clock_control_one_ff;
        end else if (hit_tmr2) begin
            rd_byte = timer_clock_control_two_ff;
        end else if (hit_stat) begin
            rd_byte = {timer_clock.lvl, uart_clock.lvl, bus_clock.lvl, processor_clock.lvl, tcyc_ff};
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_ff <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            clock_divider_mode_ff      <= RST_MODE;
            uart_clock_control_ff      <= RST_UART;
            timer_clock_control_one_ff <= RST_TMR1;
            timer_clock_control_two_ff <= RST_TMR2;
        end else if (wr_en) begin
            if (hit_mode) begin
                clock_divider_mode_ff <= {4'h0, pwdata[3:0]};
            end
            if (hit_uart) begin
                uart_clock_control_ff <= pwdata[7:0];
            end
            if (hit_tmr1) begin
                timer_clock_control_one_ff <= pwdata[7:0];
            end
            if (hit_tmr2) begin
                timer_clock_control_two_ff <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock generators; uart and timer tick every oscillator period
    assign cpu_cfg  = icdu_cpu_phase(processor_divide_select);
    assign bus_cfg  = icdu_bus_phase(bus_divide_select);
    assign uart_cfg = '{high: uart_high_count, low: uart_low_count};
    assign tmr_cfg  = '{high: timer_high_count,
                        low:  (tcyc_ff == timer_alternate_trigger_count) ?
                              timer_alternate_low_count : timer_low_count};

    // divide-by-1 cannot toggle inside one period: level held high, rise every cycle
    icdu_phase_gen u_cpu (
        .core_clk (core_clk),
        .resetn   (resetn),
        .adv      (1'b1),
        .bypass   (processor_divide_select == CPU_DIV1),
        .cfg      (cpu_cfg),
        .clk_o    (processor_clock),
        .span     (cpu_span)
    );

    // bus clock counts processor clock periods
    icdu_phase_gen u_bus (
        .core_clk (core_clk),
        .resetn   (resetn),
        .adv      (processor_clock.rise),
        .bypass   (1'b0),
        .cfg      (bus_cfg),
        .clk_o    (bus_clock),
        .span     (bus_span)
    );

    icdu_phase_gen u_uart (
        .core_clk (core_clk),
        .resetn   (resetn),
        .adv      (1'b1),
        .bypass   (1'b0),
        .cfg      (uart_cfg),
        .clk_o    (uart_clock),
        .span     (uart_span)
    );

    icdu_phase_gen u_tmr (
        .core_clk (core_clk),
        .resetn   (resetn),
        .adv      (1'b1),
        .bypass   (1'b0),
        .cfg      (tmr_cfg),
        .clk_o    (timer_clock),
        .span     (tmr_span)
    );

    ////////////////////////////////////////////////////////////////////////
    // timer cycle counter; steps at each low-phase start, so it is settled when the next low
    // length is sampled even with a one-period high phase, and alt_used_ff tags the low just begun
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tcyc_ff     <= 4'h0;
            alt_used_ff <= 1'b0;
        end else if (timer_clock.fall) begin
            alt_used_ff <= (tcyc_ff == timer_alternate_trigger_count);
            tcyc_ff     <= (tcyc_ff == timer_alternate_trigger_count) ? 4'h0 : tcyc_ff + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks; phase lengths only judged once settings have been quiet a while, except the uart runt check which always applies
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            quiet_ff <= 6'h00;
        end else if (wr_en) begin
            quiet_ff <= 6'h00;
        end else if (quiet_ff != QUIET_CYCLES) begin
            quiet_ff <= quiet_ff + 6'h01;
        end
    end
    assign quiet = (quiet_ff == QUIET_CYCLES);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_cpu_div1;
        quiet && processor_divide_select == CPU_DIV1 |-> processor_clock.lvl && processor_clock.rise;
    endproperty
    a_cpu_div1: assert property (p_cpu_div1) else $error("cpu divide-by-1 not passing oscillator");

    property p_cpu_div4_period;
        quiet && processor_divide_select == CPU_DIV4 && processor_clock.rise
            |-> ##1 !processor_clock.rise [*3] ##1 processor_clock.rise;
    endproperty
    a_cpu_div4_period: assert property (p_cpu_div4_period) else $error("cpu divide-by-4 period wrong");

    property p_cpu_low;
        quiet && processor_divide_select != CPU_DIV1 && processor_clock.rise
            |-> cpu_span == {1'b0, cpu_cfg.low} + 5'h01;
    endproperty
    a_cpu_low: assert property (p_cpu_low) else $error("cpu low phase length wrong");

    property p_cpu_high;
        quiet && processor_clock.fall |-> cpu_span == {1'b0, cpu_cfg.high} + 5'h01;
    endproperty
    a_cpu_high: assert property (p_cpu_high) else $error("cpu high phase length wrong");

    property p_bus_low;
        quiet && bus_clock.rise |-> bus_span == {1'b0, bus_cfg.low} + 5'h01;
    endproperty
    a_bus_low: assert property (p_bus_low) else $error("bus low phase length wrong");

    property p_bus_high;
        quiet && bus_clock.fall |-> bus_span == {1'b0, bus_cfg.high} + 5'h01;
    endproperty
    a_bus_high: assert property (p_bus_high) else $error("bus high phase length wrong");

    property p_bus_illegal;
        bad_bus |=> clock_divider_mode_ff == $past(clock_divider_mode_ff);
    endproperty
    a_bus_illegal: assert property (p_bus_illegal) else $error("illegal bus code stored");

    property p_mode_write;
        wr_en && hit_mode |=> processor_divide_select == $past(pwdata[1:0])
                              && bus_divide_select == $past(pwdata[3:2]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode fields not at index 01");

    property p_uart_low;
        quiet && uart_clock.rise |-> uart_span == {1'b0, uart_low_count} + 5'h01;
    endproperty
    a_uart_low: assert property (p_uart_low) else $error("uart low phase length wrong");

    property p_uart_high;
        quiet && uart_clock.fall |-> uart_span == {1'b0, uart_high_count} + 5'h01;
    endproperty
    a_uart_high: assert property (p_uart_high) else $error("uart high phase length wrong");

    property p_tmr_low;
        quiet && timer_clock.rise |-> tmr_span == {1'b0, (alt_used_ff ? timer_alternate_low_count
                                                                       : timer_low_count)} + 5'h01;
    endproperty
    a_tmr_low: assert property (p_tmr_low) else $error("timer low phase length wrong");

    property p_tmr_high;
        quiet && timer_clock.fall |-> tmr_span == {1'b0, timer_high_count} + 5'h01;
    endproperty
    a_tmr_high: assert property (p_tmr_high) else $error("timer high phase length wrong");

    property p_no_runt;
        uart_clock.fall |-> $past(uart_clock.lvl) && uart_span != 5'h00;
    endproperty
    a_no_runt: assert property (p_no_runt) else $error("uart phase shorter than one period");

    c_alt_low:  cover property (quiet && timer_clock.rise && alt_used_ff);
    c_bus_div3: cover property (quiet && bus_divide_select == BUS_DIV3 && bus_clock.rise);
    c_slverr:   cover property (pslverr && bad_bus);
    c_cpu_div3: cover property (quiet && processor_divide_select == CPU_DIV3 && processor_clock.fall);

endmodule : icdu_top

// ### tb_top.sv
// self-checking bench for the internal clock divider unit
// assumes zero-wait apb slave and the oscillator model as core_clk
`timescale 1ns/1ps
module tb_top;
    import icdu_pkg::*;
    logic          core_clk;
    logic          resetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata;
    logic [3:0]    pstrb;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    icdu_edge_type gen [4];
    int            failures;
    int            check_count;
    logic [31:0]   rd;
    logic          err;

    icdu_osc_model i_osc (.osc_clk(core_clk));
    icdu_top i_dut (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .processor_clock(gen[0]), .bus_clock(gen[1]),
        .uart_clock(gen[2]), .timer_clock(gen[3])
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [3:0] st);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx[5:0], 2'b00};
        pwdata <= {24'h0, wd};
        pstrb <= st;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n, 1, "apb answer");
    endtask : apb

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic eerr);
        apb(1'b0, idx, 8'h00, 4'hF);
        chk(rd, exp, "read data");
        chk(err, eerr, "read error");
    endtask : rd_chk

    // low and high run lengths of one generated clock, from a fall pulse
    task automatic meas(input int w, output int lo, output int hi);
        int n;
        lo = 0;
        hi = 0;
        n = 0;
        @(negedge core_clk);
        while (gen[w].fall !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        while (gen[w].lvl === 1'b0 && lo < 40) begin
            lo++;
            @(negedge core_clk);
        end
        while (gen[w].lvl === 1'b1 && hi < 40) begin
            hi++;
            @(negedge core_clk);
        end
    endtask : meas

    // first period may still carry the old setting
    task automatic phase_chk(input int w, input int elo, input int ehi);
        int lo;
        int hi;
        meas(w, lo, hi);
        meas(w, lo, hi);
        chk(lo, elo, "low run");
        chk(hi, ehi, "high run");
    endtask : phase_chk

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk(IDX_MODE, {24'h0, RST_MODE}, 1'b0);
        rd_chk(IDX_UART, {24'h0, RST_UART}, 1'b0);
        rd_chk(IDX_TMR1, {24'h0, RST_TMR1}, 1'b0);
        rd_chk(IDX_TMR2, {24'h0, RST_TMR2}, 1'b0);
        rd_chk(8'h02, 32'h0, 1'b1);
    endtask : t_reset

    task automatic t_cpu;
        int elo [4] = '{0, 1, 2, 2};
        int ehi [4] = '{0, 1, 1, 2};
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, IDX_MODE, {4'h0, BUS_DIV2, 2'(c)}, 4'hF);
            phase_chk(0, elo[c], ehi[c]);
        end
        apb(1'b1, IDX_MODE, {4'h0, BUS_DIV2, CPU_DIV1}, 4'hF);
        repeat (4) @(negedge core_clk);
        // undivided: level stays high with a rise every cycle
        repeat (6) begin
            @(negedge core_clk);
            chk({gen[0].lvl, gen[0].rise}, 2'h3, "undivided cpu");
        end
    endtask : t_cpu

    task automatic t_bus;
        int elo [3] = '{2, 2, 1};
        int ehi [3] = '{2, 1, 1};
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, IDX_MODE, {4'h0, 2'(c), CPU_DIV1}, 4'hF);
            chk(err, 1'b0, "legal mode");
            phase_chk(1, elo[c], ehi[c]);
        end
        // bus counts processor periods, not oscillator periods
        apb(1'b1, IDX_MODE, {4'h0, BUS_DIV2, CPU_DIV2}, 4'hF);
        phase_chk(1, 2, 2);
        apb(1'b1, IDX_MODE, {4'h0, BUS_ILLEGAL, CPU_DIV4}, 4'hF);
        chk(err, 1'b1, "illegal bus code");
        apb(1'b1, IDX_MODE, {4'h0, BUS_DIV4, CPU_DIV4}, 4'h0);
        rd_chk(IDX_MODE, {28'h0, BUS_DIV2, CPU_DIV2}, 1'b0);
    endtask : t_bus

    task automatic t_uart;
        logic [7:0] v [3] = '{8'h30, 8'h0F, 8'hF0};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, IDX_UART, v[i], 4'hF);
            phase_chk(2, int'(v[i][3:0]) + 1, int'(v[i][7:4]) + 1);
        end
    endtask : t_uart

    task automatic t_timer;
        int lo;
        int hi;
        int alts;
        alts = 0;
        apb(1'b1, IDX_TMR1, 8'h21, 4'hF);
        // trigger 0 keeps the cycle count at 0; alternate low set equal to the normal low
        apb(1'b1, IDX_TMR2, 8'h10, 4'hF);
        phase_chk(3, 2, 3);
        apb(1'b1, IDX_TMR2, 8'h50, 4'hF);
        phase_chk(3, 6, 3);
        apb(1'b1, IDX_TMR2, 8'h52, 4'hF);
        meas(3, lo, hi);
        // one stretched low phase in every three periods
        repeat (6) begin
            meas(3, lo, hi);
            chk(hi, 3, "timer high");
            if (lo == 6) begin
                alts++;
            end else begin
                chk(lo, 2, "timer low");
            end
        end
        chk(alts, 2, "alternate lows");
    endtask : t_timer

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        failures = 0;
        check_count = 0;
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_cpu();
        t_bus();
        t_uart();
        t_timer();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end
endmodule : tb_top
